// File: design/splh_consts.svh
// Constants of the serial packet link host
`ifndef SPLH_CONSTS_SVH
`define SPLH_CONSTS_SVH
`define SPLH_CLK_HZ 250000000
`define SPLH_BAUD 115200
`define SPLH_BIT_CYC (`SPLH_CLK_HZ / `SPLH_BAUD)
`define SPLH_MAX_LEN 22
`define SPLH_ACK_MS 250
`define SPLH_RETRIES 3
`define SPLH_CLS_RSP 2'h1
`define SPLH_CLS_ERR 2'h3
`define SPLH_CRC_POLY 16'h8408
`define SPLH_CRC_INIT 16'hFFFF
`define SPLH_CRC_XOR 16'hFFFF
`define SPLH_FIFO_DEPTH 32
`endif

// File: design/splh_pkg.sv
// Types of the serial packet link host
package splh_pkg;
    typedef enum logic [2:0] {
        SPLH_C_IDLE = 3'h1,
        SPLH_C_SEND = 3'h2,
        SPLH_C_WAIT = 3'h4
    } splh_cmd_st_t;
    typedef enum logic [5:0] {
        SPLH_P_TYPE = 6'h01,
        SPLH_P_LEN = 6'h02,
        SPLH_P_DATA = 6'h04,
        SPLH_P_CRCL = 6'h08,
        SPLH_P_CRCH = 6'h10,
        SPLH_P_PUSH = 6'h20
    } splh_prs_st_t;
endpackage : splh_pkg

// File: design/splh_host.sv
// Host end of the serial packet link: framer, checker, acknowledge timer
`timescale 1ns/1ps
`include "splh_consts.svh"

// ==========================================================
// Packet FIFO
module splh_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic wr, rd;
    always_comb begin
        o_in_ready = (cnt != (AW+1)'(D));
        o_out_valid = (cnt != '0);
        o_out_data = mem[rp];
        wr = i_in_valid && o_in_ready;
        rd = o_out_valid && i_out_ready;
        next_wp = wr ? AW'(wp + 1'b1) : wp;
        next_rp = rd ? AW'(rp + 1'b1) : rp;
        next_cnt = cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end
    // Storage needs no reset; empty flag guards reads
    always_ff @(posedge i_mclk) begin
        if (wr) begin
            mem[wp] <= i_in_data;
        end
    end
endmodule : splh_fifo

// ==========================================================
// Host controller
module splh_host #(
    parameter int unsigned ACK_CYC = `SPLH_ACK_MS * (`SPLH_CLK_HZ / 1000),
    // Bit time in clocks; a smaller value only shortens simulation
    parameter int unsigned BAUD_DIV = `SPLH_BIT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_rxd,
    output logic o_txd,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic [5:0] i_cmd_code,
    input wire logic [4:0] i_cmd_len,
    input wire logic [175:0] i_cmd_data,
    output logic o_cmd_done,
    output logic o_cmd_nak,
    output logic o_link_error,
    output logic o_pkt_valid,
    input wire logic i_pkt_ready,
    output logic [7:0] o_pkt_type,
    output logic [4:0] o_pkt_len,
    output logic [175:0] o_pkt_data,
    output logic o_rx_drop
);
    import splh_pkg::*;
    localparam logic [11:0] BIT_CYC = 12'(BAUD_DIV);
    localparam int PW = 189;

    // ======================================================
    // Checksum
    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [7:0] b);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ b[i];
            r = r >> 1;
            if (fb) begin
                r = r ^ `SPLH_CRC_POLY;
            end
        end
        return r;
    endfunction : crc_upd

    // ======================================================
    // Serial transmitter, 8N1, free running line
    logic [9:0] tx_sh, next_tx_sh;
    logic [3:0] tx_bits, next_tx_bits;
    logic [11:0] tx_cnt, next_tx_cnt;
    logic tx_load;
    logic [7:0] tx_byte;
    always_comb begin
        next_tx_sh = tx_sh;
        next_tx_bits = tx_bits;
        next_tx_cnt = tx_cnt;
        if (tx_load) begin
            next_tx_sh = {1'b1, tx_byte, 1'b0};
            next_tx_bits = 4'hA;
            next_tx_cnt = BIT_CYC - 12'h1;
        end else if (tx_bits != 4'h0) begin
            if (tx_cnt == 12'h0) begin
                next_tx_sh = {1'b1, tx_sh[9:1]};
                next_tx_bits = tx_bits - 4'h1;
                next_tx_cnt = BIT_CYC - 12'h1;
            end else begin
                next_tx_cnt = tx_cnt - 12'h1;
            end
        end
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tx_sh <= 10'h3FF;
            tx_bits <= 4'h0;
            tx_cnt <= 12'h0;
        end else begin
            tx_sh <= next_tx_sh;
            tx_bits <= next_tx_bits;
            tx_cnt <= next_tx_cnt;
        end
    end
    assign o_txd = tx_sh[0];

    // ======================================================
    // Serial receiver, samples mid bit
    logic rx_busy, next_rx_busy, rx_vld, next_rx_vld;
    logic [3:0] rx_bit, next_rx_bit;
    logic [11:0] rx_cnt, next_rx_cnt;
    logic [7:0] rx_sh, next_rx_sh;
    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_bit = rx_bit;
        next_rx_cnt = rx_cnt;
        next_rx_sh = rx_sh;
        next_rx_vld = 1'b0;
        if (!rx_busy) begin
            if (!i_rxd) begin
                next_rx_busy = 1'b1;
                next_rx_bit = 4'h0;
                next_rx_cnt = {1'b0, BIT_CYC[11:1]};
            end
        end else if (rx_cnt != 12'h0) begin
            next_rx_cnt = rx_cnt - 12'h1;
        end else begin
            next_rx_cnt = BIT_CYC - 12'h1;
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == 4'h0) begin
                next_rx_busy = !i_rxd; // Glitch, not a start bit
            end else if (rx_bit == 4'h9) begin
                next_rx_busy = 1'b0;
                next_rx_vld = i_rxd; // Bad stop bit drops the byte
            end else begin
                next_rx_sh = {i_rxd, rx_sh[7:1]};
            end
        end
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rx_busy <= 1'b0;
            rx_bit <= 4'h0;
            rx_cnt <= 12'h0;
            rx_sh <= 8'h00;
            rx_vld <= 1'b0;
        end else begin
            rx_busy <= next_rx_busy;
            rx_bit <= next_rx_bit;
            rx_cnt <= next_rx_cnt;
            rx_sh <= next_rx_sh;
            rx_vld <= next_rx_vld;
        end
    end

    // ======================================================
    // Packet detector
    splh_prs_st_t pst, next_pst;
    logic [7:0] p_type, next_p_type, p_crcl, next_p_crcl;
    logic [4:0] p_len, next_p_len, p_cnt, next_p_cnt;
    logic [175:0] p_data, next_p_data;
    logic [15:0] p_crc, next_p_crc;
    logic f_ready, good, ack_hit, cmd_waiting;
    logic [5:0] cmd_code;
    always_comb begin
        next_pst = pst;
        next_p_type = p_type;
        next_p_crcl = p_crcl;
        next_p_len = p_len;
        next_p_cnt = p_cnt;
        next_p_data = p_data;
        next_p_crc = p_crc;
        good = 1'b0;
        o_rx_drop = rx_vld && (pst == SPLH_P_PUSH);
        unique case (pst)
            SPLH_P_TYPE: begin
                if (rx_vld) begin
                    next_p_type = rx_sh;
                    next_p_crc = crc_upd(`SPLH_CRC_INIT, rx_sh);
                    next_pst = SPLH_P_LEN;
                end
            end
            SPLH_P_LEN: begin
                if (rx_vld) begin
                    if (rx_sh > 8'(`SPLH_MAX_LEN)) begin
                        // Bad length: retry this byte as a type
                        next_p_type = rx_sh;
                        next_p_crc = crc_upd(`SPLH_CRC_INIT, rx_sh);
                    end else begin
                        next_p_len = rx_sh[4:0];
                        next_p_cnt = 5'h0;
                        next_p_data = '0;
                        next_p_crc = crc_upd(p_crc, rx_sh);
                        next_pst = (rx_sh == 8'h00) ? SPLH_P_CRCL : SPLH_P_DATA;
                    end
                end
            end
            SPLH_P_DATA: begin
                if (rx_vld) begin
                    next_p_data[8*p_cnt +: 8] = rx_sh;
                    next_p_crc = crc_upd(p_crc, rx_sh);
                    next_p_cnt = p_cnt + 5'h1;
                    if (p_cnt + 5'h1 == p_len) begin
                        next_pst = SPLH_P_CRCL;
                    end
                end
            end
            SPLH_P_CRCL: begin
                if (rx_vld) begin
                    next_p_crcl = rx_sh;
                    next_pst = SPLH_P_CRCH;
                end
            end
            SPLH_P_CRCH: begin
                if (rx_vld) begin
                    good = ({rx_sh, p_crcl} == (p_crc ^ `SPLH_CRC_XOR));
                    // Bad checksum discards the packet
                    next_pst = good ? SPLH_P_PUSH : SPLH_P_TYPE;
                end
            end
            SPLH_P_PUSH: begin
                // Bytes arriving while the FIFO is full are lost
                if (f_ready) begin
                    next_pst = SPLH_P_TYPE;
                end
            end
        endcase
        // Match by type, never by arrival order
        ack_hit = good && cmd_waiting && (p_type[5:0] == cmd_code)
            && (p_type[7:6] == `SPLH_CLS_RSP
            || p_type[7:6] == `SPLH_CLS_ERR);
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pst <= SPLH_P_TYPE;
            p_type <= 8'h00;
            p_crcl <= 8'h00;
            p_len <= 5'h0;
            p_cnt <= 5'h0;
            p_data <= '0;
            p_crc <= 16'h0000;
        end else begin
            pst <= next_pst;
            p_type <= next_p_type;
            p_crcl <= next_p_crcl;
            p_len <= next_p_len;
            p_cnt <= next_p_cnt;
            p_data <= next_p_data;
            p_crc <= next_p_crc;
        end
    end

    // Good packets, reports included, are buffered, except those that arrive while one waits for space
    splh_fifo #(.W(PW), .D(`SPLH_FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_in_valid(pst == SPLH_P_PUSH),
        .o_in_ready(f_ready),
        .i_in_data({p_type, p_len, p_data}),
        .o_out_valid(o_pkt_valid),
        .i_out_ready(i_pkt_ready),
        .o_out_data({o_pkt_type, o_pkt_len, o_pkt_data})
    );

    // ======================================================
    // Command sender and acknowledge timer
    splh_cmd_st_t cst, next_cst;
    logic [5:0] next_cmd_code;
    logic [4:0] c_len, next_c_len, idx, next_idx;
    logic [175:0] c_data, next_c_data;
    logic [15:0] c_crc, next_c_crc, crc_out;
    logic [25:0] tmr, next_tmr;
    logic [1:0] tries, next_tries;
    logic next_done, next_nak, next_lerr;
    assign cmd_waiting = (cst == SPLH_C_WAIT);
    assign o_cmd_ready = (cst == SPLH_C_IDLE);
    always_comb begin
        next_cst = cst;
        next_cmd_code = cmd_code;
        next_c_len = c_len;
        next_c_data = c_data;
        next_idx = idx;
        next_c_crc = c_crc;
        next_tmr = tmr;
        next_tries = tries;
        next_done = 1'b0;
        next_nak = 1'b0;
        next_lerr = o_link_error;
        crc_out = c_crc ^ `SPLH_CRC_XOR;
        tx_load = 1'b0;
        if (idx == 5'h0) begin
            tx_byte = {2'b00, cmd_code};
        end else if (idx == 5'h1) begin
            tx_byte = {3'b000, c_len};
        end else if (idx < c_len + 5'h2) begin
            tx_byte = c_data[8*(idx-5'h2) +: 8];
        end else if (idx == c_len + 5'h2) begin
            tx_byte = crc_out[7:0];
        end else begin
            tx_byte = crc_out[15:8];
        end
        unique case (cst)
            SPLH_C_IDLE: begin
                if (i_cmd_valid) begin
                    next_cmd_code = i_cmd_code;
                    // Overlong length is clipped to the legal maximum
                    next_c_len = (i_cmd_len > 5'(`SPLH_MAX_LEN)) ?
                        5'(`SPLH_MAX_LEN) : i_cmd_len;
                    next_c_data = i_cmd_data;
                    next_idx = 5'h0;
                    next_c_crc = `SPLH_CRC_INIT;
                    next_tries = 2'h0;
                    next_lerr = 1'b0;
                    next_cst = SPLH_C_SEND;
                end
            end
            SPLH_C_SEND: begin
                if (tx_bits == 4'h0) begin
                    tx_load = 1'b1;
                    next_idx = idx + 5'h1;
                    if (idx < c_len + 5'h2) begin
                        next_c_crc = crc_upd(c_crc, tx_byte);
                    end
                    if (idx == c_len + 5'h3) begin
                        next_tmr = 26'h0;
                        next_cst = SPLH_C_WAIT;
                    end
                end
            end
            SPLH_C_WAIT: begin
                next_tmr = tmr + 26'h1;
                if (ack_hit) begin
                    next_done = 1'b1;
                    next_nak = (p_type[7:6] == `SPLH_CLS_ERR);
                    next_cst = SPLH_C_IDLE;
                end else if (tmr == 26'(ACK_CYC - 1)) begin
                    if (tries == 2'(`SPLH_RETRIES)) begin
                        next_done = 1'b1;
                        next_lerr = 1'b1;
                        next_cst = SPLH_C_IDLE;
                    end else begin
                        next_tries = tries + 2'h1;
                        next_idx = 5'h0;
                        next_c_crc = `SPLH_CRC_INIT;
                        next_cst = SPLH_C_SEND;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cst <= SPLH_C_IDLE;
            cmd_code <= 6'h00;
            c_len <= 5'h0;
            c_data <= '0;
            idx <= 5'h0;
            c_crc <= 16'h0000;
            tmr <= 26'h0;
            tries <= 2'h0;
            o_cmd_done <= 1'b0;
            o_cmd_nak <= 1'b0;
            o_link_error <= 1'b0;
        end else begin
            cst <= next_cst;
            cmd_code <= next_cmd_code;
            c_len <= next_c_len;
            c_data <= next_c_data;
            idx <= next_idx;
            c_crc <= next_c_crc;
            tmr <= next_tmr;
            tries <= next_tries;
            o_cmd_done <= next_done;
            o_cmd_nak <= next_nak;
            o_link_error <= next_lerr;
        end
    end
endmodule : splh_host

// File: testbench/splh_host_properties.sv
// Port checker of the serial packet link host
`timescale 1ns/1ps
`include "splh_consts.svh"
module splh_host_properties #(
    parameter int unsigned BAUD_DIV = `SPLH_BIT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic o_txd,
    input wire logic i_cmd_valid,
    input wire logic o_cmd_ready,
    input wire logic o_cmd_done,
    input wire logic o_cmd_nak,
    input wire logic o_link_error,
    input wire logic o_pkt_valid,
    input wire logic i_pkt_ready,
    input wire logic [7:0] o_pkt_type,
    input wire logic [4:0] o_pkt_len,
    input wire logic [175:0] o_pkt_data
);
    // ==========================================================
    // Length of each run of the line, so bit times can be judged
    logic prev_txd;
    int low_run;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            prev_txd <= 1'b1;
            low_run <= 0;
        end else begin
            prev_txd <= o_txd;
            low_run <= (o_txd != prev_txd) ? 1 : low_run + 1;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_take;
        i_cmd_valid && o_cmd_ready;
    endsequence
    sequence s_low_end;
        o_txd && !prev_txd;
    endsequence
    chk_reset_idle_line: assert property ($fell(i_rst) |->
        o_txd && o_cmd_ready && !o_pkt_valid)
        else $error("line or ports not idle after reset");
    chk_bit_time_exact: assert property (s_low_end |->
        (low_run % BAUD_DIV) == 0)
        else $error("low run not a whole number of bits");
    chk_take_goes_busy: assert property (s_take |=>
        !o_cmd_ready [*8])
        else $error("ready again right after a command");
    chk_ready_on_done: assert property ($rose(o_cmd_ready) |->
        o_cmd_done)
        else $error("ready returned without done");
    chk_done_one_cycle: assert property (o_cmd_done |=>
        !o_cmd_done)
        else $error("done longer than one cycle");
    chk_nak_with_done: assert property (o_cmd_nak |->
        o_cmd_done)
        else $error("nak without done");
    chk_error_on_done: assert property ($rose(o_link_error) |->
        o_cmd_done && !o_cmd_nak)
        else $error("link error outside a give-up");
    chk_error_holds: assert property (o_link_error &&
        !(i_cmd_valid && o_cmd_ready) |=> o_link_error)
        else $error("link error dropped early");
    chk_head_stable: assert property (o_pkt_valid && !i_pkt_ready |=>
        o_pkt_valid && $stable(o_pkt_type) &&
        $stable(o_pkt_len) && $stable(o_pkt_data))
        else $error("head packet changed while waiting");
endmodule : splh_host_properties

bind splh_host splh_host_properties #(.BAUD_DIV(BAUD_DIV)) u_props (
    .i_mclk, .i_rst, .o_txd,
    .i_cmd_valid, .o_cmd_ready, .o_cmd_done, .o_cmd_nak, .o_link_error,
    .o_pkt_valid, .i_pkt_ready, .o_pkt_type, .o_pkt_len, .o_pkt_data);

// File: testbench/splh_dev_model.sv
// Behavioural model of the display device on the serial link
`timescale 1ns/1ps
`include "splh_consts.svh"
module splh_dev_model #(
    parameter int BAUD_DIV = `SPLH_BIT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_txd,
    input wire logic [1:0] i_mode,
    output logic o_rxd
);
    localparam int BC = BAUD_DIV;
    int good_frames = 0;
    logic [7:0] reply_type;
    event reply_go;
    int bad_frames = 0;
    int bad_class = 0;
    // Idle mark level; no flow control lines exist at all
    initial o_rxd = 1'b1;
    // ==========================================================
    // Checksum step, same settings as the host end
    function automatic logic [15:0] crc_step(input logic [15:0] c,
            input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `SPLH_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_step
    task automatic put_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd = f[i];
            repeat (BC) @(negedge i_mclk);
        end
    endtask : put_byte
    // Unprompted frames leave only when the bench calls this
    task automatic send_frame(input logic [7:0] t, input int n,
            input logic [31:0] d, input logic bad);
        logic [15:0] c;
        c = crc_step(crc_step(`SPLH_CRC_INIT, t), n[7:0]);
        put_byte(t);
        put_byte(n[7:0]);
        for (int i = 0; i < n; i++) begin
            c = crc_step(c, d[8*i +: 8]);
            put_byte(d[8*i +: 8]);
        end
        c = c ^ `SPLH_CRC_XOR ^ {15'h0000, bad};
        put_byte(c[7:0]);
        put_byte(c[15:8]);
    endtask : send_frame
    task automatic get_byte(output logic [7:0] b);
        @(negedge i_txd);
        repeat (BC / 2) @(posedge i_mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BC) @(posedge i_mclk);
            b[i] = i_txd;
        end
        repeat (BC) @(posedge i_mclk);
    endtask : get_byte
    // ==========================================================
    // Commands in, one answer per good frame unless told silent
    initial begin : rx_loop
        logic [7:0] t, n, b, lo, hi;
        logic [15:0] c;
        forever begin
            get_byte(t);
            get_byte(n);
            c = crc_step(crc_step(`SPLH_CRC_INIT, t), n);
            for (int i = 0; i < n; i++) begin
                get_byte(b);
                c = crc_step(c, b);
            end
            get_byte(lo);
            get_byte(hi);
            if ({hi, lo} !== (c ^ `SPLH_CRC_XOR)) begin
                bad_frames++;
            end else begin
                good_frames++;
                if (t[7:6] !== 2'h0) bad_class++;
                if (i_mode == 2'h0) begin
                    reply_type = {2'h1, t[5:0]};
                    -> reply_go;
                end
                if (i_mode == 2'h1) begin
                    reply_type = {2'h3, t[5:0]};
                    -> reply_go;
                end
            end
        end
    end
    // Replies leave from their own process: the host may start its next
    // command while the last stop bit of a reply is still on the line
    initial begin : tx_loop
        forever begin
            @(reply_go);
            repeat (1000) @(negedge i_mclk);
            send_frame(reply_type, 0, 32'h0, 1'b0);
        end
    end
endmodule : splh_dev_model

// File: testbench/splh_host_bench.sv
// Self-checking bench of the serial packet link host
`timescale 1ns/1ps
module splh_host_bench;
    import splh_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_rxd;
    logic o_txd;
    logic i_cmd_valid = 1'b0;
    logic o_cmd_ready;
    logic [5:0] i_cmd_code = 6'h00;
    logic [4:0] i_cmd_len = 5'h00;
    logic [175:0] i_cmd_data = '0;
    logic o_cmd_done, o_cmd_nak, o_link_error, o_pkt_valid, o_rx_drop;
    logic i_pkt_ready = 1'b0;
    logic [7:0] o_pkt_type;
    logic [4:0] o_pkt_len;
    logic [175:0] o_pkt_data;
    logic [1:0] dev_mode = 2'h0;
    int bad_count = 0;
    int cmp_count = 0;
    int drop_cnt = 0;
    always #2 i_mclk = ~i_mclk;
    // Drop pulses last one cycle; count them where they are settled
    always @(negedge i_mclk) begin
        if (o_rx_drop === 1'b1) begin
            drop_cnt++;
        end
    end
    // Short bit time and answer timer keep the run brief; the timer
    // still covers a full reply frame
    localparam int unsigned DIV = 16;
    splh_host #(.ACK_CYC(4000), .BAUD_DIV(DIV)) uut (.i_mclk, .i_rst,
        .i_rxd, .o_txd,
        .i_cmd_valid, .o_cmd_ready, .i_cmd_code, .i_cmd_len, .i_cmd_data,
        .o_cmd_done, .o_cmd_nak, .o_link_error, .o_pkt_valid,
        .i_pkt_ready, .o_pkt_type, .o_pkt_len, .o_pkt_data, .o_rx_drop);
    splh_dev_model #(.BAUD_DIV(DIV)) dev (.i_mclk, .i_txd(o_txd),
        .i_mode(dev_mode), .o_rxd(i_rxd));
    // ==========================================================
    // Compare tasks
    task automatic fail(input string what);
        bad_count++;
        $display("MISMATCH t=%0t %s", $time, what);
    endtask : fail
    task automatic check_bit(input logic got, input logic exp,
            input string what);
        cmp_count++;
        if (got !== exp) fail(what);
    endtask : check_bit
    task automatic check_int(input int got, input int exp,
            input string what);
        cmp_count++;
        if (got != exp) fail(what);
    endtask : check_int
    task automatic check_head(input logic [7:0] t, input int n,
            input logic [31:0] d);
        cmp_count++;
        if (o_pkt_valid !== 1'b1 || o_pkt_type !== t ||
                o_pkt_len !== n[4:0] || o_pkt_data !== {144'h0, d}) begin
            fail("head packet");
        end
        i_pkt_ready = 1'b1;
        @(negedge i_mclk);
        i_pkt_ready = 1'b0;
        @(negedge i_mclk);
    endtask : check_head
    // One command, waited for under a bound
    task automatic run_cmd(input logic [5:0] code, input int n,
            input logic [1:0] mode, input logic nak, input logic err);
        dev_mode = mode;
        i_cmd_code = code;
        i_cmd_len = n[4:0];
        i_cmd_data = {160'h0, 16'h3CA5};
        i_cmd_valid = 1'b1;
        @(negedge i_mclk);
        i_cmd_valid = 1'b0;
        check_bit(o_cmd_ready, 1'b0, "ready after take");
        for (int k = 0; k < 30000 && o_cmd_done !== 1'b1; k++) begin
            @(negedge i_mclk);
        end
        check_bit(o_cmd_done, 1'b1, "done");
        check_bit(o_cmd_nak, nak, "nak");
        check_bit(o_link_error, err, "link error");
    endtask : run_cmd
    // ==========================================================
    // Scenarios
    task automatic t_ping;
        run_cmd(6'h05, 2, 2'h0, 1'b0, 1'b0);
        check_int(dev.good_frames, 1, "frame count");
        check_int(dev.bad_frames, 0, "bad frames");
        check_int(dev.bad_class, 0, "command class");
    endtask : t_ping
    task automatic t_err_reply;
        run_cmd(6'h06, 0, 2'h1, 1'b1, 1'b0);
        check_int(dev.good_frames, 2, "frame count");
    endtask : t_err_reply
    task automatic t_silent;
        run_cmd(6'h07, 0, 2'h2, 1'b0, 1'b1);
        check_int(dev.good_frames, 6, "resend count");
    endtask : t_silent
    task automatic t_reports;
        dev.send_frame(8'h80, 1, 32'h0000000C, 1'b1);
        dev.send_frame(8'h80, 1, 32'h0000000C, 1'b0);
        dev.send_frame(8'h81, 4, 32'h34122003, 1'b0);
        dev.send_frame(8'h82, 4, 32'h01FFE805, 1'b0);
        repeat (10) @(negedge i_mclk);
        check_bit(o_pkt_valid, 1'b1, "reports held");
    endtask : t_reports
    // Arrival order kept, bad frame gone, answers and reports mixed
    task automatic t_drain;
        check_head(8'h45, 0, 32'h0);
        check_head(8'hC6, 0, 32'h0);
        check_head(8'h80, 1, 32'h0000000C);
        check_head(8'h81, 4, 32'h34122003);
        check_head(8'h82, 4, 32'h01FFE805);
        check_bit(o_pkt_valid, 1'b0, "buffer empty");
    endtask : t_drain
    // Thirty-two packets fill the buffer, the next one stalls, and
    // every byte of the one after it is lost
    task automatic t_overflow;
        for (int k = 0; k < 33; k++) begin
            dev.send_frame(8'h80, 1, 32'h00000001, 1'b0);
        end
        dev.send_frame(8'h80, 1, 32'h00000007, 1'b0);
        repeat (10) @(negedge i_mclk);
        check_int(drop_cnt, 5, "dropped bytes");
        check_head(8'h80, 1, 32'h00000001);
    endtask : t_overflow
    // ==========================================================
    // Sequence, watchdog and verdict
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        t_ping();
        t_err_reply();
        t_silent();
        t_reports();
        t_drain();
        t_overflow();
        summarize();
    end
    // Whole run is near 55000 cycles; allow 80000
    initial begin : watchdog
        #320000;
        fail("watchdog expired");
        summarize();
    end
endmodule : splh_host_bench
